// file: servo_cmd_params.svh
// Bit positions, mode codes and timing figures for the command input block.
// Assumes the includer compiles it once; guarded against double inclusion.
`ifndef SERVO_CMD_PARAMS_SVH
`define SERVO_CMD_PARAMS_SVH

`define PAR_W              16
`define SW1_FWD_IGNORE     4'h2
`define SW1_REV_IGNORE     4'h3
`define SW1_STOP_B0        4'h6
`define SW1_STOP_B1        4'h8
`define SW1_STOP_B2        4'h9
`define SW1_PIN15_INHIBIT  4'hF
`define SW2_DUAL_SPEED     4'h2
`define SW2_MODE_LSB       4'h3
`define SW2_MODE_MSB       4'h5
`define SW2_CLR_EDGE       4'hA
`define SW2_INVERT         4'hD
`define MODE_PULSE_DIR     3'h0
`define MODE_FWD_REV       3'h1
`define MODE_QUAD_X1       3'h2
`define MODE_QUAD_X2       3'h3
`define MODE_QUAD_X4       3'h4
`define SPD_CODE_ONE       2'h1
`define SPD_CODE_TWO       2'h2
`define SPD_CODE_THREE     2'h3
`define CLR_MIN_NS         20000
`define CLK_PERIOD_NS      4
`define CLR_CNT_W          16

`endif

// file: servo_cmd_pkg.sv
// Types shared by the command input block and its environment.
// Assumes servo_cmd_params.svh is on the include path.
`include "servo_cmd_params.svh"

package servo_cmd_pkg;

  typedef enum logic [2:0] {
    PULSE_DIR, FWD_REV, QUAD_X1, QUAD_X2, QUAD_X4, MODE_ILLEGAL
  } pulse_mode_t;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
  } pulse_pair_t;

  typedef struct packed {
    logic               active;
    logic               reverse;
    logic [`PAR_W-1:0]  value;
  } speed_out_t;

  function automatic pulse_mode_t decode_mode(input logic [2:0] code);
    case (code)
      `MODE_PULSE_DIR: decode_mode = PULSE_DIR;
      `MODE_FWD_REV:   decode_mode = FWD_REV;
      `MODE_QUAD_X1:   decode_mode = QUAD_X1;
      `MODE_QUAD_X2:   decode_mode = QUAD_X2;
      `MODE_QUAD_X4:   decode_mode = QUAD_X4;
      default:         decode_mode = MODE_ILLEGAL;
    endcase
  endfunction

endpackage

// file: servo_command_input_logic.sv
// Command pulse decode, deviation counter, clear input, overtravel,
// dual-use limit/speed inputs and alarm reset of a pulse-train driver.
// Assumes all inputs are synchronous to clk_sys_i (250 MHz).
//
// Overview of operation
// - Drive in a direction allowed only while its overtravel input is on or ignored.
// - Prohibited drive stops with the method set by word one bits 6,8,9.
// - An overtravel stop never raises the alarm.
// - Word one bits 2 and 3 set make the overtravel inputs ignored.
// - Position loop is off during an overtravel stop.
// - Word two bit 2 clear: dual inputs are current limits with own values.
// - Word two bit 2 set: dual inputs pick preset speed, pin 15 direction.
// - Alarm clears when the alarm reset input turns on.
// - Counter clear empties the counter and disables the position loop.
// - Counter clear acts only after being held at least 20 us.
// - Word two bit A picks level or rising-edge clear sensing.
// - Mode bits 5..3: pulse+direction, fwd/rev pulses, quadrature.
// - Quadrature codes count one, two or four steps per cycle.
// - Word two bit d inverts the command input polarity.
// - First pair is pulse/reverse/A, second is direction/forward/B.
// - Command timing is the same in negative logic.
// - Pulse stop selected and on: command pulses are ignored.
`timescale 1ns/1ps
`include "servo_cmd_params.svh"

module servo_command_input_logic #(
  parameter int DEV_W       = 32,
  parameter int CLR_MIN_CYC =
    (`CLR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic [`PAR_W-1:0]          setup_word_one_i,
  input  wire logic [`PAR_W-1:0]          setup_word_two_i,
  input  wire servo_cmd_pkg::pulse_pair_t cmd_pair_i,
  input  wire logic                       counter_clear_in_i,
  input  wire logic                       fwd_overtravel_in_i,
  input  wire logic                       rev_overtravel_in_i,
  input  wire logic                       fwd_current_limit_in_i,
  input  wire logic                       rev_current_limit_in_i,
  input  wire logic                       pin15_in_i,
  input  wire logic                       alarm_reset_in_i,
  input  wire logic                       alarm_event_i,
  input  wire logic [`PAR_W-1:0]          fwd_ext_limit_value_i,
  input  wire logic [`PAR_W-1:0]          rev_ext_limit_value_i,
  input  wire logic [`PAR_W-1:0]          preset_speed_one_i,
  input  wire logic [`PAR_W-1:0]          preset_speed_two_i,
  input  wire logic [`PAR_W-1:0]          preset_speed_three_i,
  output logic signed [DEV_W-1:0]         deviation_count_o,
  output logic                            counter_clear_o,
  output logic                            position_loop_en_o,
  output logic                            fwd_drive_en_o,
  output logic                            rev_drive_en_o,
  output logic                            ot_stop_o,
  output logic [2:0]                      stop_method_o,
  output logic                            alarm_o,
  output logic                            fwd_limit_active_o,
  output logic [`PAR_W-1:0]               fwd_limit_value_o,
  output logic                            rev_limit_active_o,
  output logic [`PAR_W-1:0]               rev_limit_value_o,
  output servo_cmd_pkg::speed_out_t       speed_o
);

  localparam logic [`CLR_CNT_W-1:0] CLR_CNT = CLR_MIN_CYC[`CLR_CNT_W-1:0];
  localparam int CLR_CHK = CLR_MIN_CYC;

  if (DEV_W < 8 || CLR_MIN_CYC < 1 ||
      CLR_MIN_CYC > ((1 << `CLR_CNT_W) - 1)) begin : g_chk
    $error("Unsupported DEV_W or CLR_MIN_CYC");
  end

  servo_cmd_pkg::pulse_mode_t mode;
  servo_cmd_pkg::pulse_pair_t pair_q;
  servo_cmd_pkg::pulse_pair_t pair_d;
  logic                       invert;
  logic                       dual_speed;
  logic                       inhibit_sel;
  logic                       inhibit;
  logic                       step_fwd;
  logic                       step_rev;
  logic                       raw_fwd;
  logic                       raw_rev;
  logic                       a_edge;
  logic                       b_edge;
  logic [`CLR_CNT_W-1:0]      clr_hi_cnt;
  logic                       clr_qual;
  logic                       clr_qual_d;
  logic                       clear_now;
  logic                       allow_fwd;
  logic                       allow_rev;
  logic                       next_ot_stop;
  logic                       alarm_reset_d;
  logic [1:0]                 spd_code;

  assign mode        = servo_cmd_pkg::decode_mode(
                         setup_word_two_i[`SW2_MODE_MSB:`SW2_MODE_LSB]);
  assign invert      = setup_word_two_i[`SW2_INVERT];
  assign dual_speed  = setup_word_two_i[`SW2_DUAL_SPEED];
  assign inhibit_sel = !dual_speed && setup_word_one_i[`SW1_PIN15_INHIBIT];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pair_q <= '0;
      pair_d <= '0;
    end else begin
      pair_q <= cmd_pair_i ^ {invert, invert};
      pair_d <= pair_q;
    end
  end

  assign a_edge = pair_q.phase_a != pair_d.phase_a;
  assign b_edge = pair_q.phase_b != pair_d.phase_b;

  always_comb begin
    raw_fwd = 1'b0;
    raw_rev = 1'b0;
    unique case (mode)
      servo_cmd_pkg::PULSE_DIR: begin
        if (a_edge && pair_q.phase_a) begin
          raw_fwd = pair_q.phase_b;
          raw_rev = !pair_q.phase_b;
        end
      end
      servo_cmd_pkg::FWD_REV: begin
        raw_fwd = b_edge && pair_q.phase_b;
        raw_rev = a_edge && pair_q.phase_a;
      end
      servo_cmd_pkg::QUAD_X1: begin
        if (a_edge && !b_edge && pair_q.phase_a) begin
          raw_fwd = !pair_q.phase_b;
          raw_rev = pair_q.phase_b;
        end
      end
      servo_cmd_pkg::QUAD_X2: begin
        if (a_edge && !b_edge) begin
          raw_fwd = pair_q.phase_a != pair_q.phase_b;
          raw_rev = pair_q.phase_a == pair_q.phase_b;
        end
      end
      servo_cmd_pkg::QUAD_X4: begin
        if (a_edge && !b_edge) begin
          raw_fwd = pair_q.phase_a != pair_q.phase_b;
          raw_rev = pair_q.phase_a == pair_q.phase_b;
        end else if (b_edge && !a_edge) begin
          raw_fwd = pair_q.phase_b == pair_q.phase_a;
          raw_rev = pair_q.phase_b != pair_q.phase_a;
        end
      end
      servo_cmd_pkg::MODE_ILLEGAL: begin
        raw_fwd = 1'b0;
        raw_rev = 1'b0;
      end
    endcase
  end

  assign inhibit  = inhibit_sel && pin15_in_i;
  assign step_fwd = raw_fwd && !raw_rev && !inhibit;
  assign step_rev = raw_rev && !raw_fwd && !inhibit;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clr_hi_cnt <= '0;
    end else if (!counter_clear_in_i) begin
      clr_hi_cnt <= '0;
    end else if (clr_hi_cnt != CLR_CNT) begin
      clr_hi_cnt <= clr_hi_cnt + 1'b1;
    end
  end

  assign clr_qual = counter_clear_in_i && (clr_hi_cnt == CLR_CNT);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clr_qual_d <= 1'b0;
    end else begin
      clr_qual_d <= clr_qual;
    end
  end

  assign clear_now = setup_word_two_i[`SW2_CLR_EDGE] ?
                     (clr_qual && !clr_qual_d) : clr_qual;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      deviation_count_o <= '0;
      counter_clear_o   <= 1'b0;
    end else begin
      counter_clear_o <= clear_now;
      if (clear_now) begin
        deviation_count_o <= '0;
      end else if (step_fwd) begin
        deviation_count_o <= deviation_count_o + 1'b1;
      end else if (step_rev) begin
        deviation_count_o <= deviation_count_o - 1'b1;
      end
    end
  end

  assign allow_fwd = fwd_overtravel_in_i ||
                     setup_word_one_i[`SW1_FWD_IGNORE];
  assign allow_rev = rev_overtravel_in_i ||
                     setup_word_one_i[`SW1_REV_IGNORE];
  assign next_ot_stop =
    (deviation_count_o > 0 && !allow_fwd) ||
    (deviation_count_o < 0 && !allow_rev);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_drive_en_o     <= 1'b0;
      rev_drive_en_o     <= 1'b0;
      ot_stop_o          <= 1'b0;
      stop_method_o      <= '0;
      position_loop_en_o <= 1'b0;
    end else begin
      fwd_drive_en_o     <= allow_fwd;
      rev_drive_en_o     <= allow_rev;
      ot_stop_o          <= next_ot_stop;
      stop_method_o      <= {setup_word_one_i[`SW1_STOP_B2],
                             setup_word_one_i[`SW1_STOP_B1],
                             setup_word_one_i[`SW1_STOP_B0]};
      position_loop_en_o <= !clear_now && !next_ot_stop;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_o       <= 1'b0;
      alarm_reset_d <= 1'b0;
    end else begin
      alarm_reset_d <= alarm_reset_in_i;
      if (alarm_event_i) begin
        alarm_o <= 1'b1;
      end else if (alarm_reset_in_i && !alarm_reset_d) begin
        alarm_o <= 1'b0;
      end
    end
  end

  assign spd_code = {rev_current_limit_in_i, fwd_current_limit_in_i};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_limit_active_o <= 1'b0;
      rev_limit_active_o <= 1'b0;
      fwd_limit_value_o  <= '0;
      rev_limit_value_o  <= '0;
      speed_o            <= '0;
    end else begin
      fwd_limit_active_o <= !dual_speed && fwd_current_limit_in_i;
      rev_limit_active_o <= !dual_speed && rev_current_limit_in_i;
      fwd_limit_value_o  <= fwd_ext_limit_value_i;
      rev_limit_value_o  <= rev_ext_limit_value_i;
      speed_o.active     <= dual_speed && (spd_code != 2'h0);
      speed_o.reverse    <= dual_speed && pin15_in_i;
      unique case (spd_code)
        `SPD_CODE_ONE:   speed_o.value <= preset_speed_one_i;
        `SPD_CODE_TWO:   speed_o.value <= preset_speed_two_i;
        `SPD_CODE_THREE: speed_o.value <= preset_speed_three_i;
        default:         speed_o.value <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence fwd_step_s;
    step_fwd && !clear_now;
  endsequence

  sequence count_up_s;
    ##1 deviation_count_o == $past(deviation_count_o) + 1'b1;
  endsequence

  sequence long_clear_s;
    clr_qual && !clr_qual_d;
  endsequence

  fwd_prohibit_a: assert property (
    !fwd_overtravel_in_i && !setup_word_one_i[`SW1_FWD_IGNORE]
    |=> !fwd_drive_en_o)
    else $error("Forward drive allowed without overtravel input");

  ot_ignore_a: assert property (
    setup_word_one_i[`SW1_REV_IGNORE] |=> rev_drive_en_o)
    else $error("Reverse overtravel not ignored");

  ot_no_alarm_a: assert property (
    $rose(alarm_o) |-> $past(alarm_event_i))
    else $error("Alarm raised without an alarm event");

  ot_loop_off_a: assert property (
    deviation_count_o > 0 && !fwd_overtravel_in_i &&
    !setup_word_one_i[`SW1_FWD_IGNORE]
    |=> ot_stop_o && !position_loop_en_o)
    else $error("Position loop on during overtravel stop");

  alarm_clear_a: assert property (
    alarm_reset_in_i && !alarm_reset_d && !alarm_event_i |=> !alarm_o)
    else $error("Alarm not cleared by reset input");

  clear_width_a: assert property (
    long_clear_s |-> $past(counter_clear_in_i, CLR_CHK))
    else $error("Counter clear accepted a short pulse");

  clear_effect_a: assert property (
    clear_now |=> deviation_count_o == 0 && !position_loop_en_o
                  && counter_clear_o)
    else $error("Counter clear did not empty counter");

  edge_once_a: assert property (
    setup_word_two_i[`SW2_CLR_EDGE] && clear_now
    ##1 setup_word_two_i[`SW2_CLR_EDGE] |-> !clear_now)
    else $error("Edge mode clear repeated");

  step_up_a: assert property (
    fwd_step_s |-> count_up_s)
    else $error("Forward step not added");

  inhibit_hold_a: assert property (
    inhibit && !clear_now |=> $stable(deviation_count_o))
    else $error("Pulse counted during pulse stop");

  speed_pick_a: assert property (
    dual_speed && spd_code == `SPD_CODE_TWO
    |=> speed_o.active && speed_o.value == $past(preset_speed_two_i))
    else $error("Preset speed two not selected");

endmodule

// file: cmd_pulse_source.sv
// Model of the motion controller that sends command pulses.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/1ps
module cmd_pulse_source (
  input  wire logic                  clk_i,
  output servo_cmd_pkg::pulse_pair_t cmd_pair_o
);
  initial cmd_pair_o = '0;

  // Idle pair in the given polarity, no wait
  task automatic set_idle(input logic inv);
    cmd_pair_o <= {inv, inv};
  endtask

  // One pair level held for three clocks
  task automatic put(input logic a, input logic b, input logic inv);
    @(negedge clk_i);
    cmd_pair_o <= {a ^ inv, b ^ inv};
    repeat (2) @(negedge clk_i);
  endtask

  task automatic send(input logic [2:0] code, input logic inv,
                      input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      case (code)
        // Pulse on first pair, direction on second
        3'h0: begin
          put(1'b0, fwd, inv);
          put(1'b1, fwd, inv);
        end
        // Reverse on first pair, forward on second
        3'h1: begin
          put(!fwd, fwd, inv);
          put(1'b0, 1'b0, inv);
        end
        default: begin
          put(fwd, !fwd, inv);
          put(1'b1, 1'b1, inv);
          put(!fwd, fwd, inv);
          put(1'b0, 1'b0, inv);
        end
      endcase
    end
    put(1'b0, 1'b0, inv);
  endtask
endmodule

// file: tb.sv
// Self-checking bench: table of pulse runs, then clear, overtravel,
// limit/speed, pulse stop and alarm cases. Assumes cmd_pulse_source.
`timescale 1ns/1ps
`include "servo_cmd_params.svh"
module tb;
  typedef struct {
    logic [2:0] code;
    logic       inv;
    logic       fwd;
    int         n;
    int         delta;
  } row_t;

  logic                        clk, rst, clr, fot, rot, fcl, rcl, p15;
  logic                        arst, aev, clr_o, ploop, fen, ren, ots;
  logic                        alm, fla, rla;
  logic [15:0]                 sw1, sw2, flv, rlv;
  logic [2:0]                  stm;
  logic signed [31:0]          cnt, exp_cnt;
  servo_cmd_pkg::speed_out_t   spd;
  servo_cmd_pkg::pulse_pair_t  pair;
  int                          failures, total_checks;
  logic [15:0]                 spv [4] = '{16'h0000, 16'h0AAA,
                                           16'h0BBB, 16'h0CCC};
  row_t rows [13] = '{
    '{3'h0, 1'b0, 1'b1, 3, 3}, '{3'h0, 1'b0, 1'b0, 2, -2},
    '{3'h0, 1'b1, 1'b1, 2, 2}, '{3'h1, 1'b0, 1'b1, 3, 3},
    '{3'h1, 1'b0, 1'b0, 1, -1}, '{3'h1, 1'b1, 1'b0, 2, -2},
    '{3'h2, 1'b0, 1'b1, 2, 2}, '{3'h2, 1'b1, 1'b0, 1, -1},
    '{3'h3, 1'b0, 1'b1, 2, 4}, '{3'h3, 1'b0, 1'b0, 1, -2},
    '{3'h4, 1'b0, 1'b1, 1, 4}, '{3'h4, 1'b1, 1'b0, 2, -8},
    '{3'h5, 1'b0, 1'b1, 2, 0}};

  cmd_pulse_source u_src (.clk_i(clk), .cmd_pair_o(pair));

  servo_command_input_logic #(.DEV_W(32), .CLR_MIN_CYC(8)) u_dut (
    .clk_sys_i(clk), .rst_i(rst), .setup_word_one_i(sw1),
    .setup_word_two_i(sw2), .cmd_pair_i(pair),
    .counter_clear_in_i(clr), .fwd_overtravel_in_i(fot),
    .rev_overtravel_in_i(rot), .fwd_current_limit_in_i(fcl),
    .rev_current_limit_in_i(rcl), .pin15_in_i(p15),
    .alarm_reset_in_i(arst), .alarm_event_i(aev),
    .fwd_ext_limit_value_i(16'h1111), .rev_ext_limit_value_i(16'h2222),
    .preset_speed_one_i(spv[1]), .preset_speed_two_i(spv[2]),
    .preset_speed_three_i(spv[3]), .deviation_count_o(cnt),
    .counter_clear_o(clr_o), .position_loop_en_o(ploop),
    .fwd_drive_en_o(fen), .rev_drive_en_o(ren), .ot_stop_o(ots),
    .stop_method_o(stm), .alarm_o(alm), .fwd_limit_active_o(fla),
    .fwd_limit_value_o(flv), .rev_limit_active_o(rla),
    .rev_limit_value_o(rlv), .speed_o(spd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for the clear to act
  task automatic wait_clr;
    int i;
    for (i = 0; i < 20 && clr_o !== 1'b1; i++) cyc(1);
    if (i == 20) begin
      failures++;
      final_report();
    end
  endtask

  initial begin
    {rst, fot, rot} = 3'h7;
    {clr, fcl, rcl, p15, arst, aev} = 6'h00;
    sw1 = 16'h0000;
    sw2 = 16'h0008;
    failures = 0;
    total_checks = 0;
    exp_cnt = 0;
    cyc(10);
    chk({cnt, clr_o, fen, ren, ots, alm, spd}, 64'h0);
    rst = 1'b0;
    cyc(2);
    foreach (rows[k]) begin
      sw2 = {2'h0, rows[k].inv, 7'h00, rows[k].code, 3'h0};
      u_src.set_idle(rows[k].inv);
      u_src.send(rows[k].code, rows[k].inv, rows[k].fwd, rows[k].n);
      cyc(4);
      exp_cnt += rows[k].delta;
      chk(cnt, exp_cnt);
    end
    sw2 = 16'h0008;
    u_src.set_idle(1'b0);
    clr = 1'b1;
    cyc(5);
    clr = 1'b0;
    cyc(3);
    chk(cnt, exp_cnt);
    clr = 1'b1;
    wait_clr();
    chk({cnt, ploop}, 64'h0);
    clr = 1'b0;
    cyc(3);
    sw2 = 16'h0408;
    clr = 1'b1;
    wait_clr();
    cyc(1);
    chk(clr_o, 1'b0);
    u_src.send(3'h1, 1'b0, 1'b1, 2);
    cyc(4);
    chk(cnt, 32'sd2);
    clr = 1'b0;
    sw2 = 16'h0008;
    fot = 1'b0;
    sw1 = 16'h0240;
    cyc(3);
    chk({fen, ren, ots, ploop, alm}, 5'b01100);
    chk(stm, 3'h5);
    sw1 = 16'h0004;
    cyc(3);
    chk({fen, ots}, 2'b10);
    {fot, rot} = 2'b10;
    sw1 = 16'h0000;
    cyc(3);
    chk({fen, ren, ots}, 3'b100);
    sw1 = 16'h0008;
    cyc(3);
    chk(ren, 1'b1);
    rot = 1'b1;
    sw1 = 16'h0000;
    {rcl, fcl} = 2'b01;
    cyc(3);
    chk({fla, rla, flv, rlv}, {2'b10, 16'h1111, 16'h2222});
    sw2 = 16'h000C;
    for (int k = 1; k < 4; k++) begin
      {rcl, fcl} = k[1:0];
      p15 = k[0];
      cyc(3);
      chk({fla, rla, spd}, {2'b00, 1'b1, k[0], spv[k]});
    end
    {rcl, fcl} = 2'b00;
    sw2 = 16'h0008;
    sw1 = 16'h8000;
    p15 = 1'b1;
    u_src.send(3'h1, 1'b0, 1'b1, 2);
    cyc(4);
    chk(cnt, 32'sd2);
    p15 = 1'b0;
    u_src.send(3'h1, 1'b0, 1'b1, 1);
    cyc(4);
    chk(cnt, 32'sd3);
    aev = 1'b1;
    cyc(1);
    aev = 1'b0;
    cyc(2);
    chk(alm, 1'b1);
    arst = 1'b1;
    cyc(3);
    chk(alm, 1'b0);
    arst = 1'b0;
    // Mid-run reset with the alarm raised and a nonzero count
    aev = 1'b1;
    cyc(1);
    aev = 1'b0;
    rst = 1'b1;
    cyc(2);
    chk({cnt, clr_o, ploop, ots, alm, spd}, 64'h0);
    rst = 1'b0;
    cyc(2);
    chk({cnt, alm, ploop}, {32'h0, 1'b0, 1'b1});
    final_report();
  end
endmodule
